// ===== rtl/four_digit_segment_scanner.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Digit enables and segment lines, decimal point included, are active low.
// - Digits are enabled one at a time in endless succession.
// - Each digit is driven once every 1 to 16 ms.
// - Refresh never slows to about 45 Hz, where flicker shows.
// - Segments carry the pattern of whichever digit is enabled.
// - Enable 0 is first position; one lights B,C; seven lights A,B,C.
// - Outside raw mode, patterns come from a sixteen-entry table indexed by digit value.
// - Scan advances every 3 ms, a full refresh every 12 ms.
// - Digit index advances circularly, each digit once per four steps.
// - Each step first drives all enables high before segments change.
// - After new segments are out, only the current digit is enabled.
// - Every segment and the decimal point is individually controllable.
module four_digit_segment_scanner #(
  parameter int DIGIT_CYCLES = seg_scan_pkg::DIGIT_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] digit_values,
  input  wire logic [3:0]  decimal_points,
  input  wire logic        raw_mode,
  input  wire logic [31:0] raw_segments_n,
  output logic             digit0_enable_n,
  output logic             digit1_enable_n,
  output logic             digit2_enable_n,
  output logic             digit3_enable_n,
  output logic             seg_a_n,
  output logic             seg_b_n,
  output logic             seg_c_n,
  output logic             seg_d_n,
  output logic             seg_e_n,
  output logic             seg_f_n,
  output logic             seg_g_n,
  output logic             decimal_point_n
);

  localparam int CNT_W = $clog2(DIGIT_CYCLES + 1);

  // Small helpers, so that the packed inputs are sliced the same way everywhere.
  // Four-bit value of digit idx, taken from its nibble of the packed word.
  function automatic logic [3:0] value_of
  (
    input logic [15:0] values,
    input logic [1:0]  idx
  );
    value_of = values[idx*4 +: 4];
  endfunction

  // The point input is active high and the pin active low, hence the inversion.
  function automatic logic point_n_of
  (
    input logic [3:0] points,
    input logic [1:0] idx
  );
    point_n_of = ~points[idx];
  endfunction

  // Seven segment bits of raw byte idx, already active low.
  function automatic logic [6:0] raw_segs_of
  (
    input logic [31:0] raw,
    input logic [1:0]  idx
  );
    raw_segs_of = raw[idx*8 +: 7];
  endfunction

  // Point bit of raw byte idx, the top bit of that byte.
  function automatic logic raw_point_of
  (
    input logic [31:0] raw,
    input logic [1:0]  idx
  );
    raw_point_of = raw[idx*8 + 7];
  endfunction

  // One-cold enable word: only digit idx is driven low, the rest stay off.
  function automatic logic [3:0] enable_for
  (
    input logic [1:0] idx
  );
    enable_for      = seg_scan_pkg::DIGIT_OFF;
    enable_for[idx] = 1'b0;
  endfunction

  // Circular successor of a digit index; the two-bit wrap takes 3 to 0.
  function automatic logic [1:0] succ_of
  (
    input logic [1:0] idx
  );
    succ_of = idx + 2'h1;
  endfunction

  // True on the last lit cycle of a step.
  function automatic logic step_done
  (
    input logic [CNT_W-1:0] count
  );
    step_done = count >= CNT_W'(DIGIT_CYCLES - 1);
  endfunction

  seg_scan_pkg::scan_state_t state_q;
  seg_scan_pkg::scan_state_t state_d;
  logic [CNT_W-1:0]          cnt_q;
  logic [CNT_W-1:0]          cnt_d;
  logic [1:0]                digit_q;
  logic [1:0]                digit_d;
  logic [3:0]                enables_n_q;
  logic [3:0]                enables_n_d;
  logic [6:0]                segs_n_q;
  logic [6:0]                segs_n_d;
  logic                      dp_n_q;
  logic                      dp_n_d;
  logic [1:0]                next_digit;
  // Next pattern, picked ahead of the blank cycle that loads it.
  logic [6:0]                next_segs_n;
  logic                      next_dp_n;

  seg_pattern_if pat ();

  seg_pattern_rom u_rom
  (
    .port_t (pat.table_side)
  );

  assign next_digit = succ_of(digit_q);
  assign pat.value  = value_of(digit_values, next_digit);

  // Pattern for the digit that comes next. It is worked out every cycle but
  // is loaded only in the blank cycle, so inputs that move while a
  // digit is lit wait for that digit's next turn.
  always_comb
  begin
    if (raw_mode)
    begin
      next_segs_n = raw_segs_of(raw_segments_n, next_digit);
      next_dp_n   = raw_point_of(raw_segments_n, next_digit);
    end
    else
    begin
      next_segs_n = pat.segs_n;
      next_dp_n   = point_n_of(decimal_points, next_digit);
    end
  end

  // One scan step, as the pins see it:
  //   LIT   the current digit is on and its pattern holds still.
  //   BLANK all enables are off, and at its end the new pattern is loaded.
  //   LOAD  the new pattern is out, and at its end only the new digit turns on.
  // The blank cycle between steps stops ghosting: the old digit never sees
  // the next digit's pattern. The lit fraction lost is two cycles in 600000.
  // A step lasts exactly DIGIT_CYCLES clocks, blank and load cycles included,
  // which is why the timer restarts at two when a digit is switched on.
  // Raising DIGIT_CYCLES above 800000 at 200 MHz would push the full refresh
  // past 16 ms and toward visible flicker.

  // Step timer.
  always_comb
  begin
    cnt_d = cnt_q;
    case (state_q)
      seg_scan_pkg::ST_LIT:
      begin
        if (step_done(cnt_q))
        begin
          cnt_d = '0;
        end
        else
        begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      seg_scan_pkg::ST_LOAD:
      begin
        cnt_d = CNT_W'(2);
      end
      default:
      begin
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Scan sequencer: which phase of the step, and which digit is current.
  always_comb
  begin
    state_d = state_q;
    digit_d = digit_q;
    case (state_q)
      seg_scan_pkg::ST_LIT:
      begin
        if (step_done(cnt_q))
        begin
          state_d = seg_scan_pkg::ST_BLANK;
        end
      end
      seg_scan_pkg::ST_BLANK:
      begin
        digit_d = next_digit;
        state_d = seg_scan_pkg::ST_LOAD;
      end
      seg_scan_pkg::ST_LOAD:
      begin
        state_d = seg_scan_pkg::ST_LIT;
      end
      default:
      begin
        state_d = seg_scan_pkg::ST_LIT;
      end
    endcase
  end

  // Reset leaves digit 3 current so the first step lands on digit 0.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= seg_scan_pkg::ST_BLANK;
      digit_q <= 2'h3;
    end
    else
    begin
      state_q <= state_d;
      digit_q <= digit_d;
    end
  end

  // Pin drivers. Enables go off before the segments move and come back on
  // only a cycle after, so a pattern is never shown on the wrong digit.
  always_comb
  begin
    enables_n_d = enables_n_q;
    segs_n_d    = segs_n_q;
    dp_n_d      = dp_n_q;
    case (state_q)
      seg_scan_pkg::ST_LIT:
      begin
        if (step_done(cnt_q))
        begin
          enables_n_d = seg_scan_pkg::DIGIT_OFF;
        end
      end
      seg_scan_pkg::ST_BLANK:
      begin
        segs_n_d = next_segs_n;
        dp_n_d   = next_dp_n;
      end
      seg_scan_pkg::ST_LOAD:
      begin
        enables_n_d = enable_for(digit_q);
      end
      default:
      begin
        enables_n_d = seg_scan_pkg::DIGIT_OFF;
      end
    endcase
  end

  // Segments hold, then take the new pattern, while every enable is off; nothing is
  // lit then, so the dark lines need not be blanked as well.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      enables_n_q <= seg_scan_pkg::DIGIT_OFF;
      segs_n_q    <= seg_scan_pkg::SEG_OFF;
      dp_n_q      <= 1'b1;
    end
    else
    begin
      enables_n_q <= enables_n_d;
      segs_n_q    <= segs_n_d;
      dp_n_q      <= dp_n_d;
    end
  end

  assign digit0_enable_n = enables_n_q[0];
  assign digit1_enable_n = enables_n_q[1];
  assign digit2_enable_n = enables_n_q[2];
  assign digit3_enable_n = enables_n_q[3];
  assign seg_a_n         = segs_n_q[0];
  assign seg_b_n         = segs_n_q[1];
  assign seg_c_n         = segs_n_q[2];
  assign seg_d_n         = segs_n_q[3];
  assign seg_e_n         = segs_n_q[4];
  assign seg_f_n         = segs_n_q[5];
  assign seg_g_n         = segs_n_q[6];
  assign decimal_point_n = dp_n_q;

endmodule // four_digit_segment_scanner

// ===== rtl/seg_scan_pkg.sv
package seg_scan_pkg;

  localparam int          CLK_HZ          = 200_000_000;
  localparam int          NUM_DIGITS      = 4;
  localparam int          DIGIT_W         = 2;
  localparam int          SEG_W           = 7;
  // Time each digit stays lit, in microseconds; 3 ms gives a 12 ms refresh.
  localparam int          DIGIT_TIME_US   = 3000;
  localparam int          DIGIT_CYCLES    = (CLK_HZ / 1_000_000) * DIGIT_TIME_US;
  // Reference timer period for the same 3 ms step, kept for comparison.
  localparam int          SCAN_PERIOD_SETTING = 3750;
  // Longest and shortest legal refresh intervals in microseconds.
  localparam int          REFRESH_MAX_US  = 16000;
  localparam int          REFRESH_MIN_US  = 1000;
  localparam int          BLANK_CYCLES    = 1;
  localparam logic [6:0]  SEG_OFF         = 7'h7F;
  localparam logic [3:0]  DIGIT_OFF       = 4'hF;
  localparam logic [1:0]  DIGIT_RESET     = 2'h0;

  typedef enum logic [1:0] {
    ST_LIT,
    ST_BLANK,
    ST_LOAD
  } scan_state_t;

endpackage

// ===== rtl/seg_pattern_if.sv
`timescale 1ns/1ps
interface seg_pattern_if;
  logic [3:0] value;
  logic [6:0] segs_n;

  modport user
  (
    output value,
    input  segs_n
  );
  modport table_side
  (
    input  value,
    output segs_n
  );
endinterface

// ===== rtl/seg_pattern_rom.sv
`timescale 1ns/1ps
// Bit order of segs_n is {g,f,e,d,c,b,a}; a zero lights a segment.
module seg_pattern_rom
(
  seg_pattern_if.table_side port_t
);

  always_comb
  begin
    case (port_t.value)
      4'h0:    port_t.segs_n = 7'h40;
      4'h1:    port_t.segs_n = 7'h79;
      4'h2:    port_t.segs_n = 7'h24;
      4'h3:    port_t.segs_n = 7'h30;
      4'h4:    port_t.segs_n = 7'h19;
      4'h5:    port_t.segs_n = 7'h12;
      4'h6:    port_t.segs_n = 7'h02;
      4'h7:    port_t.segs_n = 7'h78;
      4'h8:    port_t.segs_n = 7'h00;
      4'h9:    port_t.segs_n = 7'h10;
      4'hA:    port_t.segs_n = 7'h08;
      4'hB:    port_t.segs_n = 7'h03;
      4'hC:    port_t.segs_n = 7'h46;
      4'hD:    port_t.segs_n = 7'h21;
      4'hE:    port_t.segs_n = 7'h06;
      4'hF:    port_t.segs_n = 7'h0E;
      default: port_t.segs_n = 7'h7F;
    endcase
  end

endmodule // seg_pattern_rom

// ===== dv/seg_display_model.sv
`timescale 1ns/1ps
// Keeps what each digit last showed; the segment lines are shared, so a
// pattern only counts for the digit whose enable is low.
module seg_display_model
(
  input wire logic       ref_clk,
  input wire logic [3:0] en_n,
  input wire logic [7:0] seg_n
);
  logic [7:0] shown [4];

  always @(posedge ref_clk)
    for (int k = 0; k < 4; k++)
      if (!en_n[k]) shown[k] <= seg_n;
endmodule // seg_display_model

// ===== dv/seg_scan_assertions.sv
`timescale 1ns/1ps
module seg_scan_assertions #(
  parameter int DIGIT_CYCLES = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic digit0_enable_n,
  input wire logic digit1_enable_n,
  input wire logic digit2_enable_n,
  input wire logic digit3_enable_n,
  input wire logic seg_a_n,
  input wire logic seg_b_n,
  input wire logic seg_c_n,
  input wire logic seg_d_n,
  input wire logic seg_e_n,
  input wire logic seg_f_n,
  input wire logic seg_g_n,
  input wire logic decimal_point_n
);
  wire  [3:0]  en = {digit3_enable_n, digit2_enable_n, digit1_enable_n, digit0_enable_n};
  wire  [7:0]  seg = {decimal_point_n, seg_g_n, seg_f_n, seg_e_n,
                      seg_d_n, seg_c_n, seg_b_n, seg_a_n};
  wire         lit = en != 4'hF;
  wire  [3:0]  rot = {en[2:0], en[3]};
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb cnt_d = lit ? cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) cnt_q <= rst ? 32'h0 : cnt_d;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_hot; $onehot0(~en); endproperty
  a_hot: assert property (p_hot) else $error("two digits enabled");
  property p_rst; disable iff (1'b0) rst |=> en == 4'hF && seg == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  property p_start; $fell(rst) |-> ##[1:4] en == 4'hE; endproperty
  a_start: assert property (p_start) else $error("scan not restarted at digit 0");
  property p_blank; $fell(lit) |=> !lit ##1 lit; endproperty
  a_blank: assert property (p_blank) else $error("blank gap wrong");
  property p_seg; $changed(seg) |-> !lit ##1 lit; endproperty
  a_seg: assert property (p_seg) else $error("segments changed while lit");
  property p_hold; lit |-> $stable(seg); endproperty
  a_hold: assert property (p_hold) else $error("segments moved under a lit digit");
  // A step is DIGIT_CYCLES clocks, of which two are dark.
  property p_len; $fell(lit) |-> cnt_q == DIGIT_CYCLES - 2; endproperty
  a_len: assert property (p_len) else $error("digit lit time wrong");
  property p_rot; $fell(lit) |-> ##2 en == $past(rot, 3); endproperty
  a_rot: assert property (p_rot) else $error("digit order wrong");
  c_step: cover property ($fell(lit));
  c_last: cover property (en == 4'h7);
  c_rst: cover property ($fell(rst));
endmodule // seg_scan_assertions

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int STEP = 8;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] digit_values = 16'h0000;
  logic [3:0]  decimal_points = 4'h0;
  logic        raw_mode = 1'b0;
  logic [31:0] raw_segments_n = 32'h00000000;
  logic        digit0_enable_n, digit1_enable_n, digit2_enable_n, digit3_enable_n;
  logic        seg_a_n, seg_b_n, seg_c_n, seg_d_n, seg_e_n, seg_f_n, seg_g_n, decimal_point_n;
  wire  [3:0]  en_w = {digit3_enable_n, digit2_enable_n, digit1_enable_n, digit0_enable_n};
  wire  [7:0]  seg_w = {decimal_point_n, seg_g_n, seg_f_n, seg_e_n,
                        seg_d_n, seg_c_n, seg_b_n, seg_a_n};
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [6:0]  tbl [16] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78,
                            7'h00, 7'h10, 7'h08, 7'h03, 7'h46, 7'h21, 7'h06, 7'h0E};

  always #2.5 ref_clk = ~ref_clk;

  four_digit_segment_scanner #(.DIGIT_CYCLES(STEP)) DUT (.*);
  seg_display_model pm (.ref_clk(ref_clk), .en_n(en_w), .seg_n(seg_w));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task stop_test;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Five steps let every digit take its new input at least once.
  task t_table;
    for (int v = 0; v < 16; v++)
    begin
      digit_values <= {4'(v + 3), 4'(v + 2), 4'(v + 1), 4'(v)};
      decimal_points <= 4'(v);
      repeat (5 * STEP) @(posedge ref_clk);
      for (int k = 0; k < 4; k++) chk(pm.shown[k], {~v[k], tbl[4'(v + k)]});
    end
  endtask

  task t_raw;
    raw_mode <= 1'b1;
    raw_segments_n <= 32'h5AC3817E;
    repeat (5 * STEP) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) chk(pm.shown[k], raw_segments_n[8 * k +: 8]);
    raw_mode <= 1'b0;
  endtask

  task t_rst;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(seg_w, 8'hFF);
    chk({4'hF, en_w}, 8'hFF);
    rst <= 1'b0;
    repeat (6 * STEP) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_table();
    t_raw();
    t_rst();
    stop_test();
  end
endmodule // tb_top

bind four_digit_segment_scanner seg_scan_assertions #(.DIGIT_CYCLES(DIGIT_CYCLES)) u_chk (.*);
